// ---- common/bier_regs.svh ----
`ifndef BIER_REGS_SVH
`define BIER_REGS_SVH

// ---------------------------------------------------------------
// Register indices; byte address is four times the index
// ---------------------------------------------------------------
`define BIER_IDX_BIAS    6'h04
`define BIER_IDX_ID      6'h05
`define BIER_IDX_ERR     6'h06
`define BIER_IDX_ERR_EN  6'h07
`define BIER_IDX_INT_MSK 6'h08

// ---------------------------------------------------------------
// Field positions and writable masks
// ---------------------------------------------------------------
`define BIER_BIAS_WMASK  16'hcc33
`define BIER_ERR_WMASK   16'h0e00
`define BIER_ERR_LSB     9
`define BIER_ERR_POS_BIT 11
`define BIER_ID_REV_LSB  2
`define BIER_ID_MOD_LSB  0

// ---------------------------------------------------------------
// Reset values and bus responses
// ---------------------------------------------------------------
`define BIER_BIAS_RST    16'h0000
`define BIER_ERR_RST     3'h0
`define BIER_MASK_RST    16'h0000
`define BIER_RESP_OKAY   2'h0
`define BIER_RESP_SLVERR 2'h2

`endif

// ---- common/bier_pkg.sv ----
package bier_pkg;

   // Write channel sequencing
   typedef enum logic [1:0]
   {
      BIER_WR_COLLECT = 2'b01,
      BIER_WR_RESP    = 2'b10
   } bier_wr_state_t;

   // One bit per range detector: [2] positive, [1] negative, [0] reference
   typedef logic [2:0] bier_err_vec_t;

endpackage

// ---- common/bier_err_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// Error flag control between register decode and flag keeper
interface bier_err_if;
   bier_pkg::bier_err_vec_t clr;
   bier_pkg::bier_err_vec_t en;
   bier_pkg::bier_err_vec_t flags;

   modport ctrl (output clr, output en, input flags);
   modport flag (input clr, input en, output flags);
endinterface

`default_nettype wire

// ---- core/bier_err_flags.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bier_regs.svh"

module bier_err_flags
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Raw detector levels from the analog side
   input  wire bier_pkg::bier_err_vec_t rangeAsync,
   // Flag control
   bier_err_if.flag                     err
);

   bier_pkg::bier_err_vec_t meta_r;
   bier_pkg::bier_err_vec_t sync_r;
   bier_pkg::bier_err_vec_t flags_r;
   bier_pkg::bier_err_vec_t flags_nxt;
   bier_pkg::bier_err_vec_t setNow;

   // ---------------------------------------------------------------
   // Detector synchroniser
   // ---------------------------------------------------------------
   // Detectors are asynchronous; only sync_r reads meta_r
   always_ff @(posedge clk)
   begin
      meta_r <= rst ? 3'h0 : rangeAsync;
      sync_r <= rst ? 3'h0 : meta_r;
   end

   // ---------------------------------------------------------------
   // Sticky flags
   // ---------------------------------------------------------------
   // Detection only counts where enabled; set beats a same-cycle clear
   assign setNow    = sync_r & err.en;
   assign flags_nxt = (flags_r & ~err.clr) | setNow;

   always_ff @(posedge clk)
   begin
      flags_r <= rst ? `BIER_ERR_RST : flags_nxt;
   end

   assign err.flags = flags_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_flag_needs_cause: assert property (
      $rose(flags_r[0]) |-> $past(sync_r[0] && err.en[0]))
      else $error("reference flag rose without enabled detection");

   a_flag_sets_next: assert property (
      (sync_r[2] && err.en[2]) |=> flags_r[2])
      else $error("positive input flag missed an enabled detection");

   a_flag_holds_set: assert property (
      (flags_r[1] && !err.clr[1]) |=> flags_r[1])
      else $error("negative input flag dropped without a clear");

   c_flag_cleared: cover property (flags_r[2] ##1 err.clr[2] ##1 !flags_r[2]);

endmodule

`default_nettype wire

// ---- core/bier_regbank.sv ----
// What this block does
// - The bias register sits at index 0x04, is 16 bits wide and resets to zero.
// - Bits 15 and 14 of the bias register enable bias on inputs 7 and 6, read/write.
// - Bits 11 and 10 of the bias register enable bias on inputs 5 and 4, read/write.
// - Bits 5, 4, 1 and 0 of the bias register enable bias on inputs 3, 2, 1 and 0, read/write.
// - A set enable bit drives bias onto its pin and a cleared one removes it.
// - The identification register is an 8-bit read-only register at index 0x05.
// - Its bits 3:2 hold the silicon revision, bits 1:0 the model, bits 7:4 read zero.
// - The error register sits at index 0x06, resets to zero and is write-one-to-clear.
// - An error flag can only set while its bit in the error enable register is set.
// - Bit 11 sets on a range fault at the positive input and stays set until cleared.
// - Bit 10 sets on a range fault at the negative input and stays set until cleared.
// - Bit 9 sets on a range fault at the reference input and stays set until cleared.
`timescale 1ns/1ns
`default_nettype none
`include "bier_regs.svh"

module bier_regbank
#(
   parameter int          ADDR_W    = 8,
   parameter logic [1:0]  SILICON_REV = 2'h2,  // Arbitrary value
   parameter logic [1:0]  MODEL_CODE  = 2'h3   // Arbitrary value
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Range detector levels, asynchronous
   input  wire logic              posInputRange,
   input  wire logic              negInputRange,
   input  wire logic              referenceRange,
   // Bias enables per analog input, bit n is input n
   output logic [7:0]             biasOutput,
   // Interrupt
   output logic                   irq
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("ADDR_W must lie between 8 and 32");
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Byte-lane merge of a 16-bit register, limited to its writable bits
   function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [15:0] wmask);
      logic [15:0] merged;
      merged[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merged[15:8] = strb[1] ? data[15:8] : old[15:8];
      return merged & wmask;
   endfunction

   // Word index of a byte address; out-of-range high bits force a miss
   function automatic logic [6:0] wordIndex(input logic [ADDR_W-1:0] addr);
      logic [6:0] idx;
      idx = {1'b0, addr[7:2]};
      if (ADDR_W > 8 && (addr >> 8) != '0)
      begin
         idx = 7'h7f;
      end
      return idx;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   bier_pkg::bier_wr_state_t wrState_r;
   bier_pkg::bier_wr_state_t wrState_nxt;
   logic [6:0]  awIdx_r;
   logic        awFull_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic        wFull_r;
   logic [1:0]  bresp_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        rvalid_r;
   logic [15:0] bias_r;
   logic [15:0] errEn_r;
   logic [15:0] intMask_r;
   logic        irq_r;

   bier_err_if errBus ();

   // ---------------------------------------------------------------
   // Write channel decode
   // ---------------------------------------------------------------
   // Address and data are taken independently, committed once both held
   logic        awTake;
   logic        wTake;
   logic        wrCommit;
   logic        wrBias;
   logic        wrId;
   logic        wrErr;
   logic        wrErrEn;
   logic        wrIntMsk;
   logic        wrHit;

   assign s_axi_awready = (wrState_r == bier_pkg::BIER_WR_COLLECT) && !awFull_r;
   assign s_axi_wready  = (wrState_r == bier_pkg::BIER_WR_COLLECT) && !wFull_r;
   assign awTake        = s_axi_awvalid && s_axi_awready;
   assign wTake         = s_axi_wvalid && s_axi_wready;
   assign wrCommit      = (wrState_r == bier_pkg::BIER_WR_COLLECT) && awFull_r && wFull_r;
   assign wrBias        = wrCommit && awIdx_r == {1'b0, `BIER_IDX_BIAS};
   assign wrId          = wrCommit && awIdx_r == {1'b0, `BIER_IDX_ID};
   assign wrErr         = wrCommit && awIdx_r == {1'b0, `BIER_IDX_ERR};
   assign wrErrEn       = wrCommit && awIdx_r == {1'b0, `BIER_IDX_ERR_EN};
   assign wrIntMsk      = wrCommit && awIdx_r == {1'b0, `BIER_IDX_INT_MSK};
   // Writes to the read-only identification word are accepted and dropped
   assign wrHit         = wrBias || wrId || wrErr || wrErrEn || wrIntMsk;
   assign s_axi_bvalid  = (wrState_r == bier_pkg::BIER_WR_RESP);
   assign s_axi_bresp   = bresp_r;

   always_comb
   begin
      wrState_nxt = wrState_r;
      case (wrState_r)
         bier_pkg::BIER_WR_COLLECT:
            if (wrCommit)
            begin
               wrState_nxt = bier_pkg::BIER_WR_RESP;
            end
         bier_pkg::BIER_WR_RESP:
            if (s_axi_bready)
            begin
               wrState_nxt = bier_pkg::BIER_WR_COLLECT;
            end
         default:
            wrState_nxt = bier_pkg::BIER_WR_COLLECT;
      endcase
   end

   // Write channel holding registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wrState_r <= bier_pkg::BIER_WR_COLLECT;
         awFull_r  <= 1'b0;
         wFull_r   <= 1'b0;
         awIdx_r   <= 7'h00;
         wData_r   <= 32'h0000_0000;
         wStrb_r   <= 4'h0;
         bresp_r   <= `BIER_RESP_OKAY;
      end
      else
      begin
         wrState_r <= wrState_nxt;
         awFull_r  <= awTake || (awFull_r && !wrCommit);
         wFull_r   <= wTake || (wFull_r && !wrCommit);
         awIdx_r   <= awTake ? wordIndex(s_axi_awaddr) : awIdx_r;
         wData_r   <= wTake ? s_axi_wdata : wData_r;
         wStrb_r   <= wTake ? s_axi_wstrb : wStrb_r;
         bresp_r   <= wrCommit ? (wrHit ? `BIER_RESP_OKAY : `BIER_RESP_SLVERR) : bresp_r;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Reserved bias bits can never be written, so they always read zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bias_r    <= `BIER_BIAS_RST;
         errEn_r   <= `BIER_MASK_RST;
         intMask_r <= `BIER_MASK_RST;
      end
      else
      begin
         if (wrBias)
         begin
            bias_r <= mergeLanes(bias_r, wData_r, wStrb_r, `BIER_BIAS_WMASK);
         end
         if (wrErrEn)
         begin
            errEn_r <= mergeLanes(errEn_r, wData_r, wStrb_r, `BIER_ERR_WMASK);
         end
         if (wrIntMsk)
         begin
            intMask_r <= mergeLanes(intMask_r, wData_r, wStrb_r, `BIER_ERR_WMASK);
         end
      end
   end

   // Pin map: 15,14 -> 7,6; 11,10 -> 5,4; 5,4 -> 3,2; 1,0 -> 1,0
   assign biasOutput = {bias_r[15:14], bias_r[11:10], bias_r[5:4], bias_r[1:0]};

   // ---------------------------------------------------------------
   // Error flags
   // ---------------------------------------------------------------
   // A written one in byte lane 1 clears; zeros leave flags untouched
   logic [15:0] errWord;

   assign errBus.clr = (wrErr && wStrb_r[1]) ? wData_r[`BIER_ERR_POS_BIT:`BIER_ERR_LSB] : 3'h0;
   assign errBus.en  = errEn_r[`BIER_ERR_POS_BIT:`BIER_ERR_LSB];
   assign errWord    = {4'h0, errBus.flags, 9'h000};

   bier_err_flags u_flags
   (
      .clk        (clk),
      .rst        (rst),
      .rangeAsync ({posInputRange, negInputRange, referenceRange}),
      .err        (errBus)
   );

   // Registered so the level never glitches on decode
   always_ff @(posedge clk)
   begin
      irq_r <= rst ? 1'b0 : |(errWord & intMask_r);
   end

   assign irq = irq_r;

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   logic [6:0]  arIdx;
   logic        arTake;
   logic [31:0] rdMux;
   logic        rdHit;

   assign s_axi_arready = !rvalid_r;
   assign arTake        = s_axi_arvalid && s_axi_arready;
   assign arIdx         = wordIndex(s_axi_araddr);

   // Narrow registers sit in the low bits; upper bits read zero
   always_comb
   begin
      rdHit = 1'b1;
      case (arIdx)
         {1'b0, `BIER_IDX_BIAS}:    rdMux = {16'h0000, bias_r};
         {1'b0, `BIER_IDX_ID}:      rdMux = {24'h000000, 4'h0, SILICON_REV, MODEL_CODE};
         {1'b0, `BIER_IDX_ERR}:     rdMux = {16'h0000, errWord};
         {1'b0, `BIER_IDX_ERR_EN}:  rdMux = {16'h0000, errEn_r};
         {1'b0, `BIER_IDX_INT_MSK}: rdMux = {16'h0000, intMask_r};
         default:
         begin
            rdMux = 32'h0000_0000;
            rdHit = 1'b0;
         end
      endcase
   end

   // Answer one cycle after the address is taken
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `BIER_RESP_OKAY;
      end
      else
      begin
         rvalid_r <= arTake || (rvalid_r && !s_axi_rready);
         rdata_r  <= arTake ? rdMux : rdata_r;
         rresp_r  <= arTake ? (rdHit ? `BIER_RESP_OKAY : `BIER_RESP_SLVERR) : rresp_r;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Reset itself is the trigger here, so the default disable must not apply
   a_bias_reset_zero: assert property (@(posedge clk) disable iff (1'b0) rst |=> biasOutput == 8'h00)
      else $error("bias enables not cleared by reset");

   a_bias_write_map: assert property (
      (wrBias && wStrb_r[1:0] == 2'h3)
      |=> biasOutput == $past({wData_r[15:14], wData_r[11:10], wData_r[5:4], wData_r[1:0]}))
      else $error("bias pins do not follow the written enables");

   a_bias_rsvd_zero: assert property ((bias_r & ~`BIER_BIAS_WMASK) == 16'h0000)
      else $error("reserved bias bit became set");

   a_id_read_value: assert property (
      (arTake && arIdx == {1'b0, `BIER_IDX_ID})
      |=> s_axi_rvalid && s_axi_rdata == {28'h0000000, SILICON_REV, MODEL_CODE})
      else $error("identification read returned a wrong word");

   a_err_w1c_clear: assert property (
      (errBus.clr[0] && !u_flags.setNow[0]) |=> !errBus.flags[0])
      else $error("reference flag survived a write-one clear");

   a_err_rsvd_zero: assert property (
      (arTake && arIdx == {1'b0, `BIER_IDX_ERR}) |=> s_axi_rdata[31:12] == 20'h00000)
      else $error("reserved error bits read non-zero");

   a_wr_resp_time: assert property (
      (awTake && wTake && wrState_r == bier_pkg::BIER_WR_COLLECT) |=> ##[0:1] s_axi_bvalid)
      else $error("write response late");

   c_bias_write: cover property (wrBias ##1 biasOutput != 8'h00);
   c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == `BIER_RESP_SLVERR);
   c_irq_raised: cover property ($rose(irq));

endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bier_regs.svh"

module testbench;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam logic [1:0] TB_REV   = 2'h2;  // Arbitrary value
   localparam logic [1:0] TB_MODEL = 2'h3;  // Arbitrary value
   logic        clk;
   logic        rst;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic [2:0]  range;  // [2] positive, [1] negative, [0] reference
   logic [7:0]  biasOutput;
   logic        irq;
   int          n_errors;
   int          n_tests;

   bier_regbank #(.ADDR_W(8), .SILICON_REV(TB_REV), .MODEL_CODE(TB_MODEL)) bier_regbank_i
   (
      .clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .posInputRange(range[2]), .negInputRange(range[1]), .referenceRange(range[0]),
      .biasOutput(biasOutput), .irq(irq)
   );

   // ---------------------------------------------------------------
   // Clock, reset and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      conclude();
   end

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask

   // Readiness sampled mid-cycle so the taking edge is known before it comes
   task automatic axiWrite(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
      logic a;
      logic w;
      // Pending flags: the valids written below are not visible yet
      a = 1'b1;
      w = 1'b1;
      @(posedge clk);
      awaddr  <= {idx, 2'b00};
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (a || w)
      begin
         @(negedge clk);
         a = a && !awready;
         w = w && !wready;
         @(posedge clk);
         if (!a) awvalid <= 1'b0;
         if (!w) wvalid <= 1'b0;
      end
      do @(negedge clk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic a;
      a = 1'b1;
      @(posedge clk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (a)
      begin
         @(negedge clk);
         a = !arready;
         @(posedge clk);
         if (!a) arvalid <= 1'b0;
      end
      do @(negedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   task automatic writeExpect(input logic [5:0] idx, input logic [31:0] d,
                              input logic [1:0] er, input string nm);
      logic [1:0] r;
      axiWrite(idx, d, r);
      check(nm, {30'h0, er}, {30'h0, r});
   endtask

   task automatic readExpect(input logic [5:0] idx, input logic [31:0] exp,
                             input logic [1:0] er, input string nm);
      logic [31:0] d;
      logic [1:0]  r;
      axiRead(idx, d, r);
      check(nm, exp, d);
      check(nm, {30'h0, er}, {30'h0, r});
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic resetValues;
      readExpect(`BIER_IDX_BIAS, 32'h0, 2'h0, "bias after reset");
      check("bias pins after reset", 32'h0, {24'h0, biasOutput});
      readExpect(`BIER_IDX_ERR, 32'h0, 2'h0, "error after reset");
      check("irq after reset", 32'h0, {31'h0, irq});
   endtask

   // Walk one bit through all sixteen places, then all ones and back to zero
   task automatic biasBits;
      int          pos[8] = '{0, 1, 4, 5, 10, 11, 14, 15};
      logic [31:0] rd;
      logic [7:0]  pins;
      for (int i = 0; i < 16; i++)
      begin
         rd   = 32'h0;
         pins = 8'h0;
         for (int n = 0; n < 8; n++)
         begin
            if (pos[n] == i)
            begin
               rd   = 32'h1 << i;
               pins = 8'h1 << n;
            end
         end
         writeExpect(`BIER_IDX_BIAS, 32'h1 << i, 2'h0, "bias write");
         readExpect(`BIER_IDX_BIAS, rd, 2'h0, "bias single bit");
         check("bias pins single bit", {24'h0, pins}, {24'h0, biasOutput});
      end
      writeExpect(`BIER_IDX_BIAS, 32'hffffffff, 2'h0, "bias write");
      readExpect(`BIER_IDX_BIAS, 32'hcc33, 2'h0, "bias all ones");
      check("bias pins all on", 32'hff, {24'h0, biasOutput});
      writeExpect(`BIER_IDX_BIAS, 32'h0, 2'h0, "bias write");
      check("bias pins all off", 32'h0, {24'h0, biasOutput});
      // Only lane 1 enabled: the low byte must keep its zeros
      wstrb <= 4'h2;
      writeExpect(`BIER_IDX_BIAS, 32'hffffffff, 2'h0, "bias write");
      wstrb <= 4'hf;
      readExpect(`BIER_IDX_BIAS, 32'hcc00, 2'h0, "bias upper lane");
      check("bias pins upper lane", 32'hf0, {24'h0, biasOutput});
   endtask

   task automatic idReadOnly;
      logic [31:0] id;
      id = {24'h0, 4'h0, TB_REV, TB_MODEL};
      readExpect(`BIER_IDX_ID, id, 2'h0, "identification");
      writeExpect(`BIER_IDX_ID, 32'hffffffff, 2'h0, "identification write");
      readExpect(`BIER_IDX_ID, id, 2'h0, "identification kept");
   endtask

   task automatic unmapped;
      writeExpect(6'h10, 32'hffffffff, 2'h2, "unmapped write");
      readExpect(6'h10, 32'h0, 2'h2, "unmapped read");
   endtask

   // Pulse the detector inputs set in v and give the synchroniser time to pass them on
   task automatic pulseRange(input logic [2:0] v);
      @(posedge clk);
      range <= v;
      repeat (6) @(posedge clk);
      range <= 3'h0;
      repeat (6) @(posedge clk);
   endtask

   task automatic errFlags;
      pulseRange(3'h7);
      readExpect(`BIER_IDX_ERR, 32'h0, 2'h0, "flags while disabled");
      writeExpect(`BIER_IDX_ERR_EN, 32'h0e00, 2'h0, "enable write");
      pulseRange(3'h1);
      readExpect(`BIER_IDX_ERR, 32'h0200, 2'h0, "reference flag");
      pulseRange(3'h2);
      readExpect(`BIER_IDX_ERR, 32'h0600, 2'h0, "negative flag");
      pulseRange(3'h4);
      readExpect(`BIER_IDX_ERR, 32'h0e00, 2'h0, "positive flag");
      check("irq fully masked", 32'h0, {31'h0, irq});
      writeExpect(`BIER_IDX_ERR, 32'h0, 2'h0, "error write zero");
      readExpect(`BIER_IDX_ERR, 32'h0e00, 2'h0, "flags after zero");
      writeExpect(`BIER_IDX_INT_MSK, 32'h0800, 2'h0, "mask write");
      repeat (2) @(posedge clk);
      check("irq unmasked flag", 32'h1, {31'h0, irq});
      writeExpect(`BIER_IDX_ERR, 32'hf800, 2'h0, "clear positive");
      readExpect(`BIER_IDX_ERR, 32'h0600, 2'h0, "positive cleared");
      repeat (2) @(posedge clk);
      check("irq masked flags", 32'h0, {31'h0, irq});
      writeExpect(`BIER_IDX_INT_MSK, 32'h0e00, 2'h0, "mask write");
      repeat (2) @(posedge clk);
      check("irq all unmasked", 32'h1, {31'h0, irq});
      writeExpect(`BIER_IDX_ERR, 32'h0600, 2'h0, "clear rest");
      readExpect(`BIER_IDX_ERR, 32'h0, 2'h0, "all cleared");
      repeat (2) @(posedge clk);
      check("irq after clear", 32'h0, {31'h0, irq});
   endtask

   // ---------------------------------------------------------------
   // Main sequence and verdict
   // ---------------------------------------------------------------
   task automatic conclude;
      if (n_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      n_errors = 0;
      n_tests  = 0;
      rst      = 1'b1;
      awaddr   = 8'h0;
      awvalid  = 1'b0;
      wdata    = 32'h0;
      wstrb    = 4'hf;
      wvalid   = 1'b0;
      bready   = 1'b0;
      araddr   = 8'h0;
      arvalid  = 1'b0;
      rready   = 1'b0;
      range    = 3'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      resetValues();
      biasBits();
      idReadOnly();
      unmapped();
      errFlags();
      conclude();
   end
endmodule

`default_nettype wire
